/* verification/tb_top.sv */
// Self-checking bench for the serial channel special modes
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] d;
  logic [11:0] f;
  wire [31:0] rdata_o;
  wire tx, oe, tx_irq, rx_irq, coll_irq, par_s, peer_drv;
  wire [2:0] irqs = {coll_irq, rx_irq, tx_irq};
  // Wired line with pull-up: either party pulling low wins
  wire rx_line = peer_drv & ~(oe & ~tx);
  int mismatches = 0;
  int total_checks = 0;
  always #4 ref_clk_i = ~ref_clk_i;
  ubc_uart uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .serial_rx_pin_i(rx_line),
    .ext_clock_pin_i(1'b0), .serial_tx_pin_o(tx), .serial_tx_oe_o(oe), .tx_irq_o(tx_irq),
    .rx_irq_o(rx_irq), .collision_irq_o(coll_irq), .parity_sample_o(par_s));
  ubc_peer_model peer (.ref_clk_i(ref_clk_i), .line_i(rx_line), .drive_o(peer_drv));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic wait_irq(input int b);
    int i;
    for (i = 0; i < 800; i++) begin
      tick(1);
      if (irqs[b] === 1'b1) break;
    end
    chk({31'h0, i < 800}, 32'h1);
  endtask
  // Direct format: LSB first, even parity, one stop bit
  task automatic tx_case(input logic [7:0] v, input logic nak);
    fork
      peer.capture(10, nak, f);
      wait_irq(0);
    join
    chk(f[9:0], {1'b1, ^v, v});
    chk({31'h0, ~nak}, {31'h0, par_s});
  endtask
  task automatic rx_frame(input logic [11:0] fr);
    fork
      peer.send(fr, 10);
      wait_irq(1);
    join
  endtask
  task automatic test_done;
    if (mismatches == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Budget is some 2100 cycles; this leaves ample margin
  initial begin
    #400000;
    mismatches++;
    test_done();
  end
  initial begin
    repeat (10) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    tick(1);
    chk(tx, 1);
    chk(par_s, 1);
    rd(4'h5, d);
    chk(d, 32'h3);
    rd(4'hf, d);
    chk(d, 32'h0);
    // ****************************************
    // Smart-card transmit
    // ****************************************
    wr(4'h2, 32'h0);
    wr(4'h3, 32'h0006_2045);
    wr(4'h0, 32'ha5);
    tick(40);
    chk(tx, 1);
    wr(4'h4, 32'h1);
    tx_case(8'ha5, 1'b0);
    wr(4'h0, 32'h07);
    tx_case(8'h07, 1'b1);
    wr(4'h4, 32'h0);
    tick(40);
    // ****************************************
    // Smart-card receive and error flags
    // ****************************************
    wr(4'h4, 32'h2);
    rx_frame(12'h25a);
    rd(4'h1, d);
    chk(d, 32'h5a);
    rx_frame(12'h35a);
    tick(2);
    chk(tx, 0);
    rd(4'h1, d);
    chk(d, 32'h185a);
    chk(tx, 1);
    rx_frame(12'h25a);
    rx_frame(12'h25a);
    rd(4'h1, d);
    chk(d & 32'h1e00, 32'h1200);
    wr(4'h3, 32'h0006_3845);
    rx_frame(12'h353);
    rd(4'h1, d);
    chk(d & 32'h1dff, 32'h35);
    wr(4'h3, 32'h0006_2045);
    rx_frame(12'h05a);
    rd(4'h1, d);
    chk(d & 32'h1dff, 32'h145a);
    tick(300);
    wr(4'h4, 32'h0);
    // ****************************************
    // Bus-collision mode, open-drain, auto-clear
    // ****************************************
    wr(4'h3, 32'h0008_8406);
    wr(4'h0, 32'h155);
    wr(4'h4, 32'h3);
    fork
      peer.capture(10, 1'b0, f);
      wait_irq(1);
    join
    chk(f[9:0], 10'h355);
    rd(4'h1, d);
    chk(d, 32'h155);
    wr(4'h0, 32'h1ff);
    fork
      peer.jam();
      wait_irq(2);
    join
    rd(4'h4, d);
    chk(d, 32'h2);
    rd(4'h5, d);
    chk(d & 32'h8, 32'h8);
    wr(4'h5, 32'h8);
    rd(4'h5, d);
    chk(d & 32'h8, 32'h0);
    test_done();
  end
endmodule
`default_nettype wire

/* verification/ubc_peer_model.sv */
// Far-side node: smart card or bus node on the shared pulled-up line
`timescale 1ns/1ps
`default_nettype none
module ubc_peer_model (
  input wire logic ref_clk_i,
  input wire logic line_i,
  output logic drive_o
);
  // Released line rests at the pull-up level
  initial drive_o = 1'b1;
  // Start bit, then n bits from bit 0 up, 16 clocks each
  task automatic send(input logic [11:0] fr, input int n);
    @(posedge ref_clk_i);
    drive_o <= 1'b0;
    for (int i = 0; i < n; i++) begin
      repeat (16) @(posedge ref_clk_i);
      drive_o <= fr[i];
    end
    repeat (16) @(posedge ref_clk_i);
    drive_o <= 1'b1;
  endtask
  task automatic capture(input int n, input logic nak, output logic [11:0] fr);
    fr = 12'h0;
    @(negedge line_i);
    repeat (8) @(posedge ref_clk_i);
    for (int i = 0; i < n; i++) begin
      repeat (16) @(posedge ref_clk_i);
      fr[i] = line_i;
    end
    if (nak) begin
      drive_o <= 1'b0;
      repeat (24) @(posedge ref_clk_i);
      drive_o <= 1'b1;
    end
  endtask
  // Pull the line low across the third bit of a frame
  task automatic jam;
    @(negedge line_i);
    repeat (36) @(posedge ref_clk_i);
    drive_o <= 1'b0;
    repeat (16) @(posedge ref_clk_i);
    drive_o <= 1'b1;
  endtask
endmodule
`default_nettype wire

/* verification/ubc_uart_props.sv */
// Checker for the serial channel special modes, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module ubc_uart_props (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic serial_rx_pin_i,
  input wire logic serial_tx_pin_o,
  input wire logic serial_tx_oe_o,
  input wire logic tx_irq_o,
  input wire logic rx_irq_o,
  input wire logic collision_irq_o
);
  // Shadows of software writes; autoclear is not mirrored, so tx checks stay loose
  logic [31:0] mode_sh;
  logic [7:0] div_sh;
  logic [1:0] ctrl_sh;
  int lo_cnt;
  int mis_age;
  int pre;
  int bitlen;
  wire sim = mode_sh[2:0] == 3'h5;
  wire coll = mode_sh[2:0] == 3'h6;
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mode_sh <= 32'h0;
      div_sh <= 8'h0;
      ctrl_sh <= 2'h0;
      lo_cnt <= 0;
      mis_age <= 0;
    end else begin
      if (wr_i && addr_i == 4'h3) mode_sh <= wdata_i;
      if (wr_i && addr_i == 4'h2) div_sh <= wdata_i[7:0];
      if (wr_i && addr_i == 4'h4) ctrl_sh <= wdata_i[1:0];
      lo_cnt <= serial_tx_pin_o ? 0 : lo_cnt + 1;
      mis_age <= (serial_tx_pin_o != serial_rx_pin_i) ? 0 : mis_age + 1;
    end
  end
  always_comb begin
    case (mode_sh[9:8])
      2'h0: pre = 1;
      2'h1: pre = 2;
      2'h2: pre = 8;
      default: pre = 32;
    endcase
  end
  assign bitlen = 16 * (div_sh + 1) * pre;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  a_rdata_idle: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data outside read slot");
  a_tx_irq_pulse: assert property (tx_irq_o |=> !tx_irq_o)
    else $error("tx request longer than one cycle");
  a_rx_gate: assert property (!ctrl_sh[1] && !$past(ctrl_sh[1]) |-> !rx_irq_o)
    else $error("rx request while receiver off");
  a_tx_start_gate: assert property ($fell(serial_tx_pin_o) && !ctrl_sh[1] |-> ctrl_sh[0])
    else $error("tx start while transmitter off");
  a_err_release: assert property (sim && !ctrl_sh[0] && rd_i && addr_i == 4'h1
    && !serial_tx_pin_o |=> serial_tx_pin_o)
    else $error("error signal not released by read");
  a_open_drain: assert property (coll && mode_sh[10] && mode_sh == $past(mode_sh, 2)
    && serial_tx_pin_o |-> !serial_tx_oe_o)
    else $error("open-drain pin driven high");
  a_coll_cause: assert property (collision_irq_o |-> mis_age <= bitlen + 4)
    else $error("collision without level mismatch");
  a_bit_time: assert property ($rose(serial_tx_pin_o) && sim && ctrl_sh[0] && !mode_sh[3]
    |-> lo_cnt % bitlen == 0)
    else $error("low run not a whole number of bits");
  c_tx: cover property (tx_irq_o);
  c_rx: cover property (rx_irq_o);
  c_coll: cover property (collision_irq_o);
endmodule
bind ubc_uart ubc_uart_props u_props (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .serial_rx_pin_i(serial_rx_pin_i),
  .serial_tx_pin_o(serial_tx_pin_o), .serial_tx_oe_o(serial_tx_oe_o),
  .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o), .collision_irq_o(collision_irq_o)
);
`default_nettype wire

/* verilog/ubc_defines.vh */
// Constants for the bus-collision and smart-card serial channel
`ifndef UBC_DEFINES_VH
`define UBC_DEFINES_VH
// ************************************************
// Register map (word addresses, one word each)
// ************************************************
`define UBC_ADDR_W 4
`define UBC_REG_TXBUF 4'h0
`define UBC_REG_RXBUF 4'h1
`define UBC_REG_DIV 4'h2
`define UBC_REG_MODE 4'h3
`define UBC_REG_CTRL 4'h4
`define UBC_REG_STATUS 4'h5
// ************************************************
// Mode register fields
// ************************************************
`define UBC_MODE_W 3
`define UBC_MODE_COLL 3'h6
`define UBC_MODE_SIM 3'h5
`define UBC_MODE_LO 0
`define UBC_MODE_HI 2
`define UBC_BIT_CLKDIR 3
`define UBC_BIT_STOP2 4
`define UBC_BIT_PODD 5
`define UBC_BIT_PEN 6
`define UBC_BIT_POL 7
`define UBC_SRC_LO 8
`define UBC_SRC_HI 9
`define UBC_BIT_OD 10
`define UBC_BIT_MSBF 11
`define UBC_BIT_INV 12
`define UBC_BIT_ERRSIG 13
`define UBC_BIT_SAMPEND 14
`define UBC_BIT_AUTOCLR 15
`define UBC_BIT_STARTSYNC 16
`define UBC_BIT_TXIRQSRC 17
`define UBC_BIT_CHAN2 18
`define UBC_BIT_C0EN 19
`define UBC_BIT_C1EN 20
`define UBC_BIT_CHAN1 21
// ************************************************
// Control and status bits
// ************************************************
`define UBC_CTRL_TXEN 0
`define UBC_CTRL_RXEN 1
`define UBC_ST_TXEMPTY 0
`define UBC_ST_SHEMPTY 1
`define UBC_ST_RXFULL 2
`define UBC_ST_COLL 3
`define UBC_RB_OVR 9
`define UBC_RB_FRM 10
`define UBC_RB_PAR 11
`define UBC_RB_SUM 12
// ************************************************
// Timing
// ************************************************
`define UBC_OVS 5'h10
`define UBC_OVS_MID 5'h07
`define UBC_OVS_END 5'h0f
`define UBC_DIV_W 8
`endif

/* verilog/ubc_uart.v */
// Serial channel with bus-collision and smart-card special modes
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "ubc_defines.vh"
// Behaviour
// - Collision mode sends each bus bit as one whole character frame
// - Collision mode flags when driven transmit level differs from received level
// - Collision mode buffers carry nine data bits; receive buffer shows errors
// - A bit picks the sampling instant for the collision compare
// - Auto-clear option drops transmit enable on a collision
// - A bit picks normal start or sync to received start edge
// - Polarity bit inverts transmit output and receive input in collision mode
// - Collision mode disables parity; parity type ignored
// - Output bit picks push-pull or open-drain transmit drive in collision mode
// - Smart-card mode only on channel 2, both formats, low on parity error
// - Internal clock rate is prescaled source over sixteen times divider plus one
// - External clock rate is pin frequency over sixteen times divider plus one
// - Smart-card transmit starts with enable set and buffer holding data
// - Smart-card receive starts with enable set and a start bit seen
// - Completion transmit request when shift register finished its character
// - Receive request when character moves into receive buffer
// - Overrun set when unread buffer and new character nears last stop bit
// - Framing error set when configured stop bits missing
// - Smart-card receive parity error drives transmit line low
// - Peer holds line low on error; sampled receive level at transmit request
// - Error sum set whenever overrun, framing or parity error set
// - Direct format sends LSB first, even parity; receives likewise
// - Inverse format inverts data, MSB first, odd parity, both ways
// - Receive buffer read during error signal clears parity flag, releases line
// - Framing and parity flags update when data moves into receive buffer
module ubc_uart (
  input wire ref_clk_i,
  input wire rst_i,
  input wire [3:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  input wire serial_rx_pin_i,
  input wire ext_clock_pin_i,
  output reg serial_tx_pin_o,
  output reg serial_tx_oe_o,
  output reg tx_irq_o,
  output reg rx_irq_o,
  output reg collision_irq_o,
  output reg parity_sample_o
);
  // ************************************************
  // Registers
  // ************************************************
  reg [8:0] tx_buffer_reg;
  reg [12:0] rx_buffer_reg;
  reg [7:0] baud_divider_reg;
  reg [21:0] mode_reg;
  reg tx_enable_bit;
  reg rx_enable_bit;
  reg tx_buffer_empty_flag;
  reg rx_complete_flag;
  reg collision_flag;
  reg err_sig_active;
  wire [2:0] mode_sel = mode_reg[`UBC_MODE_HI:`UBC_MODE_LO];
  wire coll_mode = (mode_sel == `UBC_MODE_COLL);
  wire sim_mode = (mode_sel == `UBC_MODE_SIM) && mode_reg[`UBC_BIT_CHAN2];
  wire pol = coll_mode && mode_reg[`UBC_BIT_POL];
  wire par_en = mode_reg[`UBC_BIT_PEN] && !coll_mode;
  wire par_odd = mode_reg[`UBC_BIT_PODD];
  wire msbf = sim_mode && mode_reg[`UBC_BIT_MSBF];
  wire dinv = sim_mode && mode_reg[`UBC_BIT_INV];
  wire nine = coll_mode;
  wire two_stop = mode_reg[`UBC_BIT_STOP2];
  wire coll_en = mode_reg[`UBC_BIT_CHAN2] ||
    (mode_reg[`UBC_BIT_CHAN1] ? mode_reg[`UBC_BIT_C1EN] : mode_reg[`UBC_BIT_C0EN]);
  // ************************************************
  // Baud clock: prescaler then divider, 16x tick
  // ************************************************
  reg [4:0] pre_cnt;
  reg [7:0] div_cnt;
  reg ext_q;
  wire ext_rise = ext_clock_pin_i && !ext_q;
  reg pre_tick;
  always @* begin
    case (mode_reg[`UBC_SRC_HI:`UBC_SRC_LO])
      2'h0: pre_tick = 1'b1;
      2'h1: pre_tick = pre_cnt[0];
      2'h2: pre_tick = &pre_cnt[2:0];
      default: pre_tick = &pre_cnt;
    endcase
  end
  wire src_tick = mode_reg[`UBC_BIT_CLKDIR] ? ext_rise : pre_tick;
  wire os_tick = src_tick && (div_cnt == 8'h00);
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      pre_cnt <= 5'h00;
      div_cnt <= 8'h00;
      ext_q <= 1'b0;
    end else begin
      ext_q <= ext_clock_pin_i;
      pre_cnt <= pre_cnt + 5'h01;
      if (src_tick) begin
        div_cnt <= (div_cnt == 8'h00) ? baud_divider_reg : div_cnt - 8'h01;
      end
    end
  end
  // ************************************************
  // Receiver
  // ************************************************
  wire rx_line = serial_rx_pin_i ^ pol;
  localparam RX_IDLE = 2'h0;
  localparam RX_START = 2'h1;
  localparam RX_DATA = 2'h2;
  localparam RX_STOP = 2'h3;
  reg [1:0] rx_state;
  reg [4:0] rx_os;
  reg [3:0] rx_bit;
  reg [9:0] rx_sh;
  reg rx_q;
  reg rx_ferr;
  wire [3:0] rx_nbits = (nine ? 4'h9 : 4'h8) + {3'h0, par_en};
  wire [3:0] rx_nstop = two_stop ? 4'h2 : 4'h1;
  wire rx_mid = os_tick && (rx_os == `UBC_OVS_MID);
  wire rx_done = rx_mid && (rx_state == RX_STOP) && (rx_bit == rx_nstop - 4'h1);
  // Overrun looks at the bit just before the final stop bit
  wire rx_last_pre = rx_mid && (two_stop ? (rx_state == RX_STOP && rx_bit == 4'h0) :
    (rx_state == RX_DATA && rx_bit == rx_nbits - 4'h1));
  wire rx_start_edge = rx_q && !rx_line;
  reg [7:0] rx_data8;
  integer k;
  integer j;
  always @* begin
    rx_data8 = 8'h00;
    for (k = 0; k < 8; k = k + 1) begin
      rx_data8[k] = msbf ? rx_sh[7 - k] : rx_sh[k];
    end
    rx_data8 = rx_data8 ^ {8{dinv}};
  end
  wire rx_par_bad = par_en &&
    ((^rx_sh[7:0]) ^ rx_sh[8] ^ (sim_mode ? dinv : par_odd));
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      rx_state <= RX_IDLE;
      rx_os <= 5'h00;
      rx_bit <= 4'h0;
      rx_sh <= 10'h000;
      rx_q <= 1'b1;
      rx_ferr <= 1'b0;
    end else begin
      rx_q <= rx_line;
      if (os_tick) begin
        rx_os <= (rx_os == `UBC_OVS_END) ? 5'h00 : rx_os + 5'h01;
      end
      case (rx_state)
        RX_IDLE: begin
          if (rx_enable_bit && rx_start_edge) begin
            rx_state <= RX_START;
            rx_os <= 5'h00;
          end
        end
        RX_START: begin
          if (rx_mid) begin
            rx_state <= rx_line ? RX_IDLE : RX_DATA;
            rx_bit <= 4'h0;
            rx_ferr <= 1'b0;
          end
        end
        RX_DATA: begin
          if (rx_mid) begin
            rx_sh[rx_bit] <= rx_line;
            rx_bit <= rx_bit + 4'h1;
            if (rx_bit == rx_nbits - 4'h1) begin
              rx_state <= RX_STOP;
              rx_bit <= 4'h0;
            end
          end
        end
        RX_STOP: begin
          if (rx_mid) begin
            if (!rx_line) begin
              rx_ferr <= 1'b1;
            end
            rx_bit <= rx_bit + 4'h1;
            if (rx_done) begin
              rx_state <= RX_IDLE;
            end
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end
  // ************************************************
  // Transmitter
  // ************************************************
  localparam TX_IDLE = 2'h0;
  localparam TX_SHIFT = 2'h1;
  localparam TX_WAIT = 2'h2;
  reg [1:0] tx_state;
  reg [11:0] tx_sh;
  reg [3:0] tx_left;
  reg [4:0] tx_os;
  reg [7:0] tx_ord;
  always @* begin
    tx_ord = 8'h00;
    for (j = 0; j < 8; j = j + 1) begin
      tx_ord[j] = msbf ? tx_buffer_reg[7 - j] : tx_buffer_reg[j];
    end
    tx_ord = tx_ord ^ {8{dinv}};
  end
  wire tx_par = (^tx_ord) ^ (sim_mode ? dinv : par_odd);
  wire tx_sync_ok = !mode_reg[`UBC_BIT_STARTSYNC] || rx_start_edge;
  wire tx_go = tx_enable_bit && !tx_buffer_empty_flag && tx_sync_ok;
  wire tx_bit_end = os_tick && (tx_os == `UBC_OVS_END);
  wire tx_finish = (tx_state == TX_SHIFT) && tx_bit_end && (tx_left == 4'h1);
  wire [3:0] tx_len = 4'h1 + (nine ? 4'h9 : 4'h8) + {3'h0, par_en} + rx_nstop;
  wire tx_level = tx_sh[0] && !err_sig_active;
  wire tx_active = (tx_state == TX_SHIFT);
  wire coll_sample = mode_reg[`UBC_BIT_SAMPEND] ? tx_bit_end : rx_mid;
  wire coll_event = coll_mode && coll_en && tx_active && coll_sample &&
    (tx_level != rx_line);
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      tx_state <= TX_IDLE;
      tx_sh <= 12'hfff;
      tx_left <= 4'h0;
      tx_os <= 5'h00;
    end else begin
      if (os_tick) begin
        tx_os <= (tx_os == `UBC_OVS_END) ? 5'h00 : tx_os + 5'h01;
      end
      case (tx_state)
        TX_IDLE: begin
          if (tx_go) begin
            // One frame per bus bit in collision mode
            tx_sh <= {2'h3, nine ? tx_buffer_reg[8] : (par_en ? tx_par : 1'b1), tx_ord,
              1'b0};
            if (par_en && nine) begin
              tx_sh[10] <= tx_par;
            end
            tx_left <= tx_len;
            tx_os <= 5'h00;
            tx_state <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          if (tx_bit_end) begin
            tx_sh <= {1'b1, tx_sh[11:1]};
            tx_left <= tx_left - 4'h1;
            if (tx_left == 4'h1) begin
              tx_state <= TX_IDLE;
            end
          end
          if (coll_event && mode_reg[`UBC_BIT_AUTOCLR]) begin
            tx_state <= TX_IDLE;
            tx_sh <= 12'hfff;
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end
  // ************************************************
  // Bus slave, flags and pins
  // ************************************************
  wire rb_read = rd_i && (addr_i == `UBC_REG_RXBUF);
  wire tb_write = wr_i && (addr_i == `UBC_REG_TXBUF);
  wire load_tx = (tx_state == TX_IDLE) && tx_go;
  wire [8:0] rx_word = nine ? rx_sh[8:0] : {1'b0, rx_data8};
  wire ovr_hit = rx_last_pre && rx_complete_flag && !rb_read;
  reg ovr_frame;
  wire [2:0] new_err = {rx_par_bad, rx_ferr || !rx_line, ovr_frame || ovr_hit};
  // Next error-signal state, so a buffer read releases the pin in the same cycle
  wire err_next = (rx_done && rx_par_bad && sim_mode && mode_reg[`UBC_BIT_ERRSIG]) ||
    (err_sig_active && !rb_read);
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      tx_buffer_reg <= 9'h000;
      rx_buffer_reg <= 13'h0000;
      baud_divider_reg <= 8'h00;
      mode_reg <= 22'h00_0000;
      tx_enable_bit <= 1'b0;
      rx_enable_bit <= 1'b0;
      tx_buffer_empty_flag <= 1'b1;
      rx_complete_flag <= 1'b0;
      collision_flag <= 1'b0;
      err_sig_active <= 1'b0;
      ovr_frame <= 1'b0;
      rdata_o <= 32'h0000_0000;
      tx_irq_o <= 1'b0;
      rx_irq_o <= 1'b0;
      collision_irq_o <= 1'b0;
      parity_sample_o <= 1'b1;
      serial_tx_pin_o <= 1'b1;
      serial_tx_oe_o <= 1'b1;
    end else begin
      if (wr_i && addr_i == `UBC_REG_DIV) begin
        baud_divider_reg <= wdata_i[7:0];
      end
      if (wr_i && addr_i == `UBC_REG_MODE) begin
        mode_reg <= wdata_i[21:0];
      end
      if (wr_i && addr_i == `UBC_REG_CTRL) begin
        tx_enable_bit <= wdata_i[`UBC_CTRL_TXEN];
        rx_enable_bit <= wdata_i[`UBC_CTRL_RXEN];
      end
      if (coll_event && mode_reg[`UBC_BIT_AUTOCLR]) begin
        tx_enable_bit <= 1'b0;
      end
      if (tb_write) begin
        tx_buffer_reg <= wdata_i[8:0];
        tx_buffer_empty_flag <= 1'b0;
      end else if (load_tx) begin
        tx_buffer_empty_flag <= 1'b1;
      end
      if (wr_i && addr_i == `UBC_REG_STATUS && wdata_i[`UBC_ST_COLL]) begin
        collision_flag <= 1'b0;
      end
      if (coll_event) begin
        collision_flag <= 1'b1;
      end
      if (rx_done) begin
        ovr_frame <= 1'b0;
      end
      if (ovr_hit) begin
        ovr_frame <= 1'b1;
        rx_buffer_reg[`UBC_RB_OVR] <= 1'b1;
        rx_buffer_reg[`UBC_RB_SUM] <= 1'b1;
      end
      if (rb_read) begin
        rx_complete_flag <= 1'b0;
        if (err_sig_active) begin
          rx_buffer_reg[`UBC_RB_PAR] <= 1'b0;
          err_sig_active <= 1'b0;
        end
      end
      // Set wins over a same-cycle read clear
      if (rx_done) begin
        rx_complete_flag <= 1'b1;
        rx_buffer_reg <= {|new_err, new_err, rx_word};
        if (rx_par_bad && sim_mode && mode_reg[`UBC_BIT_ERRSIG]) begin
          err_sig_active <= 1'b1;
        end
      end
      tx_irq_o <= (mode_reg[`UBC_BIT_TXIRQSRC] || sim_mode) ? tx_finish : load_tx;
      if (tx_finish) begin
        parity_sample_o <= serial_rx_pin_i;
      end
      rx_irq_o <= rx_done;
      collision_irq_o <= coll_event;
      // Open-drain only pulls low so several nodes share the wire
      serial_tx_pin_o <= (tx_sh[0] && !err_next) ^ pol;
      serial_tx_oe_o <= !(coll_mode && mode_reg[`UBC_BIT_OD]) || !(tx_level ^ pol);
      rdata_o <= 32'h0000_0000;
      if (rd_i) begin
        case (addr_i)
          `UBC_REG_TXBUF: rdata_o <= {23'h00_0000, tx_buffer_reg};
          `UBC_REG_RXBUF: rdata_o <= {19'h0_0000, rx_buffer_reg};
          `UBC_REG_DIV: rdata_o <= {24'h00_0000, baud_divider_reg};
          `UBC_REG_MODE: rdata_o <= {10'h000, mode_reg};
          `UBC_REG_CTRL: rdata_o <= {30'h0000_0000, rx_enable_bit, tx_enable_bit};
          `UBC_REG_STATUS: rdata_o <= {28'h000_0000, collision_flag, rx_complete_flag,
            !tx_active, tx_buffer_empty_flag};
          default: rdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire
